// ===== hdl/rtcopc_pkg.sv
// Purpose: shared constants for the output pin and trim block
// Assumes: 100 MHz system clock, crystal level arriving on a pin
// Notes: offsets are the device's byte register numbers
package rtcopc_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] ADDR_SECONDS = 8'h01;
  localparam logic [7:0] ADDR_CENTURY = 8'h03;
  localparam logic [7:0] ADDR_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_WATCHDOG = 8'h09;
  localparam logic [7:0] ADDR_ALARM_MONTH = 8'h0A;
  localparam logic [7:0] ADDR_ALARM_HOUR = 8'h0C;
  localparam logic [7:0] ADDR_FLAGS = 8'h0F;
  localparam logic [7:0] ADDR_WAVE_RATE = 8'h13;
  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_HALT = 7;
  localparam int BIT_CENTURY_EN = 7;
  localparam int BIT_CENTURY = 6;
  localparam int BIT_OUT_LEVEL = 7;
  localparam int BIT_FREQ_TEST = 6;
  localparam int BIT_CAL_SIGN = 5;
  localparam int BIT_ALARM_PIN_EN = 7;
  localparam int BIT_SQUARE_EN = 6;
  localparam int BIT_BACKUP_ALARM_EN = 5;
  localparam int BIT_FREEZE = 6;
  localparam int BIT_WD_FLAG = 7;
  localparam int BIT_ALARM_FLAG = 6;
  localparam int RATE_LSB = 4;
  localparam int FREQ_TEST_TAP = 5;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic RST_HALT = 1'b1;
  localparam logic RST_OUT_LEVEL = 1'b1;
  localparam logic RST_FREEZE = 1'b1;
  localparam logic [7:0] RST_WATCHDOG = 8'h00;
  // ****************************************
  // crystal rate and timing counts in oscillator cycles, seconds and minutes
  // ****************************************
  localparam int OSC_RATE_HZ = 32768;
  localparam logic [15:0] SECOND_LEN = 16'(OSC_RATE_HZ);
  localparam logic [15:0] CAL_SHORTEN = 16'h0080;
  localparam logic [15:0] CAL_LENGTHEN = 16'h0100;
  localparam logic [5:0] SECONDS_LAST = 6'h3B;
  localparam logic [5:0] MINUTES_LAST = 6'h3F;
endpackage

// ===== hdl/rtcopc_div_if.sv
// Purpose: carries oscillator ticks, trim settings and divider taps
// Assumes: all signals on the system clock
// Notes: ctl side is the register and pin logic
`timescale 1ns/10ps
interface rtcopc_div_if;
  logic osc_tick;
  logic halt;
  logic [4:0] cal_mag;
  logic cal_sign;
  logic [14:0] raw_cnt;
  logic second_tick;
  modport ctl (output osc_tick, halt, cal_mag, cal_sign, input raw_cnt, second_tick);
  modport div (input osc_tick, halt, cal_mag, cal_sign, output raw_cnt, second_tick);
endinterface

// ===== hdl/rtcopc_divider.sv
// Purpose: oscillator divider chain with periodic trim of the seconds count
// Assumes: osc_tick pulses once per crystal cycle
// Notes: raw taps run untrimmed so test and square waves stay exact
`timescale 1ns/10ps
module rtcopc_divider (
  input wire logic clk,
  input wire logic rst,
  rtcopc_div_if.div dv
);
  import rtcopc_pkg::*;
  logic [14:0] raw_cnt;
  logic [15:0] sec_cnt;
  logic [5:0] sec_in_min;
  logic [5:0] min_in_cycle;
  logic second_tick;
  logic [14:0] next_raw_cnt;
  logic [15:0] next_sec_cnt;
  logic [5:0] next_sec_in_min;
  logic [5:0] next_min_in_cycle;
  logic next_second_tick;
  logic affected;
  logic [15:0] sec_len;

  // ****************************************
  // divider and trim
  // ****************************************
  always_comb begin
    next_raw_cnt = raw_cnt;
    next_sec_cnt = sec_cnt;
    next_sec_in_min = sec_in_min;
    next_min_in_cycle = min_in_cycle;
    next_second_tick = 1'b0;
    // first second of each of the first 2N minutes is trimmed
    affected = (dv.cal_mag != 5'h00) && (sec_in_min == 6'h00)
      && (min_in_cycle < {dv.cal_mag, 1'b0});
    if (!affected) begin
      sec_len = SECOND_LEN;
    end else if (dv.cal_sign) begin
      sec_len = SECOND_LEN + CAL_LENGTHEN;
    end else begin
      sec_len = SECOND_LEN - CAL_SHORTEN;
    end
    if (dv.osc_tick && !dv.halt) begin
      next_raw_cnt = raw_cnt + 15'h0001;
      if (sec_cnt == sec_len - 16'h0001) begin
        next_sec_cnt = 16'h0000;
        next_second_tick = 1'b1;
        if (sec_in_min == SECONDS_LAST) begin
          next_sec_in_min = 6'h00;
          next_min_in_cycle = min_in_cycle + 6'h01;
        end else begin
          next_sec_in_min = sec_in_min + 6'h01;
        end
      end else begin
        next_sec_cnt = sec_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      raw_cnt <= 15'h0000;
      sec_cnt <= 16'h0000;
      sec_in_min <= 6'h00;
      min_in_cycle <= 6'h00;
      second_tick <= 1'b0;
    end else begin
      raw_cnt <= next_raw_cnt;
      sec_cnt <= next_sec_cnt;
      sec_in_min <= next_sec_in_min;
      min_in_cycle <= next_min_in_cycle;
      second_tick <= next_second_tick;
    end
  end

  assign dv.raw_cnt = raw_cnt;
  assign dv.second_tick = second_tick;
endmodule

// ===== hdl/rtcopc_top.sv
// Purpose: multi-function output pin, square wave, trim and power-on defaults
// Assumes: crystal level and power-fail arrive asynchronously on pins
// Notes: rst stands for first application of power
// What this block does
// - timebase divides a 32768 Hz crystal
// - rate code selects square wave frequency
// - square wave enable gates wave onto pin
// - trim inserts or removes divider counts
// - five-bit magnitude plus sign bit trim
// - 64-minute cycle, -128 or +256 cycles
// - only first 2N minutes are trimmed
// - frequency test gives 512 Hz when enabled
// - test frequency ignores trim setting
// - power-down clears frequency test bit
// - otherwise pin follows output level bit
// - power-on clears and sets control defaults
// - century flag toggles when enabled
// - watchdog wins over frequency test
// - alarm interrupt drives pin, flag read clears
`timescale 1ns/10ps
module rtcopc_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic osc_pin,
  input wire logic power_fail_pin,
  input wire logic century_rollover,
  input wire logic alarm_match,
  input wire logic wd_timeout,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  output logic [7:0] wd_setting,
  output logic wd_restart,
  output logic backup_alarm_enable,
  output logic freeze_user_copy,
  output logic second_tick,
  output logic mfo_out,
  output logic mfo_oe
);
  import rtcopc_pkg::*;
  rtcopc_div_if dv ();

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic osc_s1, osc_s2, osc_s3, pf_s1, pf_s2;
  always_ff @(posedge clk) begin
    if (rst) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
      pf_s1 <= 1'b0;
      pf_s2 <= 1'b0;
    end else begin
      osc_s1 <= osc_pin;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
      pf_s1 <= power_fail_pin;
      pf_s2 <= pf_s1;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  logic halt, century_en, century, out_level, freq_test, cal_sign;
  logic [4:0] cal_mag;
  logic alarm_pin_en, square_en, alarm_flag, wd_flag, alarm_irq, wd_irq;
  logic [3:0] wave_rate;
  logic next_halt, next_century_en, next_century, next_out_level, next_freq_test;
  logic next_cal_sign, next_alarm_pin_en, next_square_en, next_backup_alarm_enable;
  logic next_freeze_user_copy, next_alarm_flag, next_wd_flag, next_alarm_irq;
  logic next_wd_irq, next_wd_restart;
  logic [4:0] next_cal_mag;
  logic [3:0] next_wave_rate;
  logic [7:0] next_wd_setting, next_reg_rdata;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] want);
    hit = (a == want);
  endfunction

  always_comb begin
    next_halt = halt;
    next_century_en = century_en;
    next_century = century;
    next_out_level = out_level;
    next_freq_test = freq_test;
    next_cal_sign = cal_sign;
    next_cal_mag = cal_mag;
    next_wd_setting = wd_setting;
    next_alarm_pin_en = alarm_pin_en;
    next_square_en = square_en;
    next_backup_alarm_enable = backup_alarm_enable;
    next_freeze_user_copy = freeze_user_copy;
    next_wave_rate = wave_rate;
    next_alarm_flag = alarm_flag;
    next_wd_flag = wd_flag;
    next_alarm_irq = alarm_irq;
    next_wd_irq = wd_irq;
    next_wd_restart = 1'b0;
    next_reg_rdata = 8'h00;
    if (reg_re) begin
      if (hit(reg_addr, ADDR_SECONDS)) next_reg_rdata[BIT_HALT] = halt;
      if (hit(reg_addr, ADDR_CENTURY)) begin
        next_reg_rdata[BIT_CENTURY_EN] = century_en;
        next_reg_rdata[BIT_CENTURY] = century;
      end
      if (hit(reg_addr, ADDR_CONTROL)) begin
        next_reg_rdata = {out_level, freq_test, cal_sign, cal_mag};
      end
      if (hit(reg_addr, ADDR_WATCHDOG)) next_reg_rdata = wd_setting;
      if (hit(reg_addr, ADDR_ALARM_MONTH)) begin
        next_reg_rdata[BIT_ALARM_PIN_EN] = alarm_pin_en;
        next_reg_rdata[BIT_SQUARE_EN] = square_en;
        next_reg_rdata[BIT_BACKUP_ALARM_EN] = backup_alarm_enable;
      end
      if (hit(reg_addr, ADDR_ALARM_HOUR)) next_reg_rdata[BIT_FREEZE] = freeze_user_copy;
      if (hit(reg_addr, ADDR_WAVE_RATE)) next_reg_rdata = {wave_rate, 4'h0};
      if (hit(reg_addr, ADDR_FLAGS)) begin
        next_reg_rdata[BIT_WD_FLAG] = wd_flag;
        next_reg_rdata[BIT_ALARM_FLAG] = alarm_flag;
        // flag read releases the alarm drive on the pin
        next_alarm_flag = 1'b0;
        next_wd_flag = 1'b0;
        next_alarm_irq = 1'b0;
      end
    end
    if (reg_we) begin
      if (hit(reg_addr, ADDR_SECONDS)) next_halt = reg_wdata[BIT_HALT];
      if (hit(reg_addr, ADDR_CENTURY)) begin
        next_century_en = reg_wdata[BIT_CENTURY_EN];
        next_century = reg_wdata[BIT_CENTURY];
      end
      if (hit(reg_addr, ADDR_CONTROL)) begin
        {next_out_level, next_freq_test, next_cal_sign, next_cal_mag} = reg_wdata;
      end
      if (hit(reg_addr, ADDR_WATCHDOG)) begin
        next_wd_setting = reg_wdata;
        next_wd_restart = 1'b1;
        // only a write of zero frees the pin after a timeout
        if (reg_wdata == 8'h00) next_wd_irq = 1'b0;
      end
      if (hit(reg_addr, ADDR_ALARM_MONTH)) begin
        next_alarm_pin_en = reg_wdata[BIT_ALARM_PIN_EN];
        next_square_en = reg_wdata[BIT_SQUARE_EN];
        next_backup_alarm_enable = reg_wdata[BIT_BACKUP_ALARM_EN];
      end
      if (hit(reg_addr, ADDR_ALARM_HOUR)) next_freeze_user_copy = reg_wdata[BIT_FREEZE];
      if (hit(reg_addr, ADDR_WAVE_RATE)) next_wave_rate = reg_wdata[7:RATE_LSB];
    end
    // hardware events come last so they beat a same-cycle register read or write
    if (alarm_match) begin
      next_alarm_flag = 1'b1;
      if (alarm_pin_en) next_alarm_irq = 1'b1;
    end
    if (wd_timeout && wd_setting != 8'h00) begin
      next_wd_flag = 1'b1;
      next_wd_irq = 1'b1;
    end
    if (century_rollover && century_en) next_century = ~century;
    if (pf_s2) next_freq_test = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      // power-on defaults; other bits start cleared
      halt <= RST_HALT;
      out_level <= RST_OUT_LEVEL;
      freeze_user_copy <= RST_FREEZE;
      wd_setting <= RST_WATCHDOG;
      alarm_pin_en <= 1'b0;
      backup_alarm_enable <= 1'b0;
      square_en <= 1'b0;
      century_en <= 1'b0;
      century <= 1'b0;
      freq_test <= 1'b0;
      cal_sign <= 1'b0;
      cal_mag <= 5'h00;
      wave_rate <= 4'h0;
      alarm_flag <= 1'b0;
      wd_flag <= 1'b0;
      alarm_irq <= 1'b0;
      wd_irq <= 1'b0;
      wd_restart <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      halt <= next_halt;
      out_level <= next_out_level;
      freeze_user_copy <= next_freeze_user_copy;
      wd_setting <= next_wd_setting;
      alarm_pin_en <= next_alarm_pin_en;
      backup_alarm_enable <= next_backup_alarm_enable;
      square_en <= next_square_en;
      century_en <= next_century_en;
      century <= next_century;
      freq_test <= next_freq_test;
      cal_sign <= next_cal_sign;
      cal_mag <= next_cal_mag;
      wave_rate <= next_wave_rate;
      alarm_flag <= next_alarm_flag;
      wd_flag <= next_wd_flag;
      alarm_irq <= next_alarm_irq;
      wd_irq <= next_wd_irq;
      wd_restart <= next_wd_restart;
      reg_rdata <= next_reg_rdata;
    end
  end

  // ****************************************
  // divider
  // ****************************************
  assign dv.osc_tick = osc_s2 & ~osc_s3;
  assign dv.halt = halt;
  assign dv.cal_mag = cal_mag;
  assign dv.cal_sign = cal_sign;
  assign second_tick = dv.second_tick;

  rtcopc_divider u_div (
    .clk(clk),
    .rst(rst),
    .dv(dv.div)
  );

  // ****************************************
  // pin source
  // ****************************************
  logic wave, next_mfo_out, next_mfo_oe, level;
  always_comb begin
    // half-duty taps straight off the untrimmed chain
    unique case (wave_rate)
      4'h0: wave = 1'b1;
      4'h1: wave = osc_s2;
      default: wave = dv.raw_cnt[wave_rate - 4'h1];
    endcase
    next_mfo_oe = 1'b0;
    level = 1'b1;
    if (alarm_irq || wd_irq) begin
      level = 1'b0;
    end else if (freq_test && !halt && !alarm_pin_en && !square_en
      && wd_setting == 8'h00) begin
      level = dv.raw_cnt[FREQ_TEST_TAP];
    end else if (square_en) begin
      level = wave;
      // code zero gives no wave, so the pin is released rather than held high
      next_mfo_oe = (wave_rate != 4'h0);
    end else if (!freq_test && !alarm_pin_en && wd_setting == 8'h00) begin
      level = out_level;
    end
    // open drain: pull low only, except square wave drives both levels
    if (!level) next_mfo_oe = 1'b1;
    next_mfo_out = level;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mfo_out <= 1'b1;
      mfo_oe <= 1'b0;
    end else begin
      mfo_out <= next_mfo_out;
      mfo_oe <= next_mfo_oe;
    end
  end
endmodule

// ===== tb/rtcopc_far_end.sv
// Purpose: crystal source and pulled-up pin as a host or meter sees it
// Assumes: crystal half period given in ns
// Notes: crystal phase is unrelated to the system clock
`timescale 1ns/10ps
module rtcopc_far_end #(
  parameter real HALF_NS = 65.0
) (
  output logic osc_pin,
  input wire logic mfo_out,
  input wire logic mfo_oe,
  output wire logic pin
);
  // ****************************************
  // crystal and pull-up
  // ****************************************
  // crystal scaled up in rate so a run stays short; counts are what matter
  initial begin
    osc_pin = 1'b0;
    #(HALF_NS / 2.0);
    forever #(HALF_NS) osc_pin = ~osc_pin;
  end
  // released pin reads high through the pull-up resistor
  assign pin = mfo_oe ? mfo_out : 1'b1;
endmodule

// ===== tb/rtcopc_checker_sva.sv
// Purpose: pin source and register port checks at the top ports
// Assumes: register shadows follow writes seen at the port
// Notes: power-fail clearing of the test bit is not shadowed
`timescale 1ns/10ps
module rtcopc_checker
  import rtcopc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic alarm_match,
  input wire logic wd_timeout,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] wd_setting,
  input wire logic wd_restart,
  input wire logic backup_alarm_enable,
  input wire logic freeze_user_copy,
  input wire logic mfo_out,
  input wire logic mfo_oe
);
  // ****************************************
  // shadows and properties
  // ****************************************
  logic [7:0] ctl, next_ctl;
  logic [2:0] am, next_am;
  logic [3:0] rate, next_rate;
  logic lvl_mode, rate_off;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always_comb begin
    next_ctl = ctl;
    next_am = am;
    next_rate = rate;
    if (reg_we && reg_addr == ADDR_CONTROL) next_ctl = reg_wdata;
    if (reg_we && reg_addr == ADDR_ALARM_MONTH) next_am = reg_wdata[7:5];
    if (reg_we && reg_addr == ADDR_WAVE_RATE) next_rate = reg_wdata[7:4];
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl <= 8'h80;
      am <= 3'h0;
      rate <= 4'h0;
    end else begin
      ctl <= next_ctl;
      am <= next_am;
      rate <= next_rate;
    end
  end
  // stale test bit only makes these narrower, never wrong
  assign lvl_mode = !ctl[6] && am[2:1] == 2'h0 && wd_setting == 8'h00;
  assign rate_off = !ctl[6] && am[2:1] == 2'h1 && rate == 4'h0 && wd_setting == 8'h00;
  reset_defaults_a: assert property (
    $fell(rst) |-> !mfo_oe && mfo_out && wd_setting == 8'h00 && freeze_user_copy
      && !backup_alarm_enable && reg_rdata == 8'h00)
    else $error("pin or defaults wrong after reset");
  level_pin_a: assert property (
    $past(lvl_mode) |-> mfo_oe == !$past(ctl[7]))
    else $error("pin does not follow output level bit");
  rate_zero_a: assert property (
    $past(rate_off) |-> !mfo_oe)
    else $error("pin driven with rate code zero");
  high_drive_a: assert property (
    mfo_oe && mfo_out |-> $past(am[1]))
    else $error("pin driven high outside square wave mode");
  alarm_pin_a: assert property (
    alarm_match && am[2] |-> ##3 mfo_oe && !mfo_out)
    else $error("alarm did not pull pin low");
  wd_pin_a: assert property (
    wd_timeout && wd_setting != 8'h00 |-> ##3 mfo_oe && !mfo_out)
    else $error("watchdog timeout did not pull pin low");
  rdata_idle_a: assert property (
    !reg_re |=> reg_rdata == 8'h00)
    else $error("read data not zero without a read");
  wd_restart_a: assert property (
    reg_we && reg_addr == ADDR_WATCHDOG |=> wd_restart ##1 !wd_restart)
    else $error("watchdog restart pulse wrong");
endmodule
bind rtcopc_top rtcopc_checker chk (.clk(clk), .rst(rst), .alarm_match(alarm_match),
  .wd_timeout(wd_timeout), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
  .reg_re(reg_re), .reg_rdata(reg_rdata), .wd_setting(wd_setting), .wd_restart(wd_restart),
  .backup_alarm_enable(backup_alarm_enable), .freeze_user_copy(freeze_user_copy),
  .mfo_out(mfo_out), .mfo_oe(mfo_oe));

// ===== tb/test_rtc_output_pin_and_calibration.sv
// Purpose: directed bench for the output pin and trim block
// Assumes: crystal edges come from the far-end model
// Notes: trim spans whole seconds and is too long to run here
`timescale 1ns/10ps
module test_rtc_output_pin_and_calibration;
  import rtcopc_pkg::*;
  // ****************************************
  // harness and tasks
  // ****************************************
  logic clk = 1'b0, rst = 1'b1, pfail = 1'b0, cent = 1'b0, alm = 1'b0, wdt = 1'b0;
  logic we = 1'b0, re = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  logic [7:0] rdata, wd_set;
  logic osc, pin, mout, moe, wdr, bae, fuc, stick;
  int fail_count = 0, checked = 0, oc = 0, a, h, p, sc = 0;
  rtcopc_top dut (.clk(clk), .rst(rst), .osc_pin(osc), .power_fail_pin(pfail),
    .century_rollover(cent), .alarm_match(alm), .wd_timeout(wdt), .reg_addr(addr),
    .reg_wdata(wdata), .reg_we(we), .reg_re(re), .reg_rdata(rdata), .wd_setting(wd_set),
    .wd_restart(wdr), .backup_alarm_enable(bae), .freeze_user_copy(fuc),
    .second_tick(stick), .mfo_out(mout), .mfo_oe(moe));
  rtcopc_far_end far (.osc_pin(osc), .mfo_out(mout), .mfo_oe(moe), .pin(pin));
  initial forever #5 clk = ~clk;
  always @(posedge osc) oc++;
  always @(negedge clk) if (stick === 1'b1) sc++;
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(negedge clk);
    addr = ad;
    wdata = d;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] ad, input logic [7:0] exp);
    @(negedge clk);
    addr = ad;
    re = 1'b1;
    @(negedge clk);
    re = 1'b0;
    check($sformatf("reg %h", ad), 32'(exp), 32'(rdata));
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  // first edge may come from the mode switch, so it is skipped
  task automatic measure();
    @(posedge pin);
    @(posedge pin);
    a = oc;
    @(negedge pin);
    h = oc - a;
    @(posedge pin);
    p = oc - a;
  endtask
  task automatic steady(input logic v);
    int bad = 0;
    repeat (900) begin
      @(negedge clk);
      if (pin !== v) bad++;
    end
    check("pin steady", 32'h0, bad);
  endtask
  task automatic report_and_stop();
    if (fail_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #1ms;
    fail_count++;
    report_and_stop();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    logic [15:0] dflt [8] = '{16'h0180, 16'h0880, 16'h0900, 16'h0A00, 16'h0C40, 16'h0F00,
      16'h1300, 16'h1000};
    repeat (8) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) rdchk(dflt[i][15:8], dflt[i][7:0]);
    check("reset outputs", 32'h100, {moe, bae, fuc, wd_set});
    wr(ADDR_CONTROL, 8'h00);
    repeat (3) @(negedge clk);
    check("pin low", 32'h0, pin);
    wr(ADDR_CONTROL, 8'h80);
    steady(1'b1);
    // divider stands still from power-on; the rate taps need it running
    wr(ADDR_SECONDS, 8'h00);
    wr(ADDR_ALARM_MONTH, 8'h40);
    for (int c = 1; c < 9; c++) begin
      wr(ADDR_WAVE_RATE, 8'(c << 4));
      measure();
      check("wave period", (c == 1) ? 32'h1 : 32'h1 << c, p);
    end
    wr(ADDR_WAVE_RATE, 8'h00);
    steady(1'b1);
    wr(ADDR_WAVE_RATE, 8'h50);
    wr(ADDR_ALARM_MONTH, 8'h00);
    steady(1'b1);
    wr(ADDR_CONTROL, 8'h40);
    measure();
    check("test period", 32'h40, p);
    check("test high time", 32'h20, h);
    // pretend the meter read slow, so trim downward by ten steps
    wr(ADDR_CONTROL, 8'h4A);
    measure();
    check("trimmed test period", 32'h40, p);
    wr(ADDR_CONTROL, 8'h7F);
    rdchk(ADDR_CONTROL, 8'h7F);
    measure();
    check("trimmed test period", 32'h40, p);
    wr(ADDR_CONTROL, 8'h4A);
    wr(ADDR_WATCHDOG, 8'h0E);
    steady(1'b1);
    pulse(wdt);
    steady(1'b0);
    rdchk(ADDR_FLAGS, 8'h80);
    wr(ADDR_WATCHDOG, 8'h00);
    measure();
    check("test period after watchdog", 32'h40, p);
    @(negedge clk);
    pfail = 1'b1;
    repeat (4) @(negedge clk);
    pfail = 1'b0;
    rdchk(ADDR_CONTROL, 8'h0A);
    check("pin low after power fail", 32'h0, pin);
    wr(ADDR_CONTROL, 8'h80);
    wr(ADDR_WAVE_RATE, 8'h10);
    wr(ADDR_ALARM_MONTH, 8'hC0);
    pulse(alm);
    steady(1'b0);
    rdchk(ADDR_FLAGS, 8'h40);
    measure();
    check("wave after flags read", 32'h1, p);
    wr(ADDR_ALARM_MONTH, 8'h00);
    wr(ADDR_CENTURY, 8'h80);
    pulse(cent);
    rdchk(ADDR_CENTURY, 8'hC0);
    pulse(cent);
    rdchk(ADDR_CENTURY, 8'h80);
    wr(ADDR_CENTURY, 8'h40);
    pulse(cent);
    rdchk(ADDR_CENTURY, 8'h40);
    wr(8'h10, 8'hFF);
    rdchk(8'h10, 8'h00);
    // far fewer than one second of crystal cycles have run, so no tick yet
    check("second ticks", 32'h0, sc);
    report_and_stop();
  end
endmodule
